// File: core/olp_defs.vh
// Purpose: Constants for the over-limit detector and pulse routing block
// Assumes: Included by every design file of the block
// Notes:   Register offsets are the word addresses of the register port
//
// Function
// - Per phase, voltage magnitude top 16 bits above threshold sets phase and event flag.
// - Overvoltage event with irq enable high raises the interrupt request.
// - Writing one clears overvoltage event, its interrupt and all phase overvoltage flags.
// - Zero overvoltage threshold disables overvoltage judgement and its flags.
// - Per phase, current magnitude top 16 bits above threshold sets phase and event flag.
// - Overcurrent detection sets its event flag; with irq enable it raises interrupt.
// - Writing one clears overcurrent event, its interrupt and all phase overcurrent flags.
// - Zero overcurrent threshold disables overcurrent judgement and its flags.
// - Overvoltage threshold: two bytes, address 59H, resets to zero.
// - Overcurrent threshold: two bytes, address 5AH, resets to zero.
// - Pulse pin configuration: three bytes, address 60H, resets to 043210H.
// - Source codes: total P,Q,S, fundamental P,Q,S, 110 reserved, 111 off.
// - Selector 4 at bits 14:12, resets fundamental active; 111 stops output 4.
// - Selector 3 at bits 10:8, resets total apparent; 111 stops output 3.
// - Selector 2 at bits 6:4, resets total reactive; 111 stops output 2.
// - Selector 1 at bits 2:0, resets total active; 110 also total active.
// - Constant select bits 15,11,7,3 pick constant a at 0, b at 1.
`ifndef OLP_DEFS_VH
`define OLP_DEFS_VH

// ==========================================================================
// Register map
`define OLP_ADDR_W        7
`define OLP_DATA_W        24
`define OLP_ADDR_OVTHR    7'h59
`define OLP_ADDR_OCTHR    7'h5A
`define OLP_ADDR_PPCFG    7'h60
`define OLP_THR_W         16
`define OLP_THR_RST       16'h0000
`define OLP_PPCFG_RST     24'h043210
// Bits 23:19 are reserved and read as zero
`define OLP_PPCFG_MASK    24'h07FFFF

// ==========================================================================
// Pulse configuration fields
`define OLP_SEL_W         3
`define OLP_SEL1_LSB      0
`define OLP_SEL2_LSB      4
`define OLP_SEL3_LSB      8
`define OLP_SEL4_LSB      12
`define OLP_CSEL1_BIT     3
`define OLP_CSEL2_BIT     7
`define OLP_CSEL3_BIT     11
`define OLP_CSEL4_BIT     15
`define OLP_FIELD_STRIDE  4

// ==========================================================================
// Pulse source codes
`define OLP_SRC_TOT_P     3'h0
`define OLP_SRC_TOT_Q     3'h1
`define OLP_SRC_TOT_S     3'h2
`define OLP_SRC_FUN_P     3'h3
`define OLP_SRC_FUN_Q     3'h4
`define OLP_SRC_FUN_S     3'h5
`define OLP_SRC_RSVD      3'h6
`define OLP_SRC_OFF       3'h7
`define OLP_NUM_SRC       6
`define OLP_NUM_OUT       4
`define OLP_NUM_PHASE     3

// ==========================================================================
// Comparison width
`define OLP_CMP_W         16

`endif

// File: core/olp_pulse_gen.v
// Purpose: One pulse output: source pick, energy accumulation, pulse stretch
// Assumes: Energy increments arrive as one-cycle valid strobes on clk
// Notes:   Selector and constant changes take effect on the next cycle
`timescale 1ns/100ps
`include "olp_defs.vh"

module olp_pulse_gen #(
  parameter ACC_W     = 32,
  parameter INC_W     = 16,
  parameter PULSE_LEN = 4,
  parameter ALIAS_RSV = 0
) (
  // Clock and reset
  input  wire                                clk,
  input  wire                                rst,
  // Configuration
  input  wire [`OLP_SEL_W-1:0]               srcSel,
  input  wire                                constSel,
  input  wire [ACC_W-1:0]                    constA,
  input  wire [ACC_W-1:0]                    constB,
  // Energy sources
  input  wire [`OLP_NUM_SRC*INC_W-1:0]       energyInc,
  input  wire [`OLP_NUM_SRC-1:0]             energyValid,
  // Pin
  output wire                                pulseOut
);

  localparam [7:0] LEN = PULSE_LEN;

  reg  [ACC_W-1:0]      acc_reg;
  reg  [ACC_W-1:0]      acc_next;
  reg  [7:0]            cnt_reg;
  reg  [7:0]            cnt_next;
  reg                   out_reg;
  reg  [`OLP_SEL_W-1:0] code;
  reg                   enabled;
  reg  [INC_W-1:0]      inc;
  reg                   incValid;
  reg  [ACC_W:0]        sum;
  wire [ACC_W-1:0]      limit;

  // ==========================================================================
  // Source selection
  assign limit = constSel ? constB : constA;

  always @* begin
    code = srcSel;
    if (ALIAS_RSV != 0 && srcSel == `OLP_SRC_RSVD) begin
      code = `OLP_SRC_TOT_P;
    end
    // Off code never counts energy; reserved counts only when ALIAS_RSV maps it to total active
    enabled  = (code <= `OLP_SRC_FUN_S);
    inc      = {INC_W{1'b0}};
    incValid = 1'b0;
    if (enabled) begin
      inc      = energyInc[code*INC_W +: INC_W];
      incValid = energyValid[code];
    end
  end

  // ==========================================================================
  // Accumulate and fire
  always @* begin
    acc_next = acc_reg;
    cnt_next = (cnt_reg != 8'h00) ? cnt_reg - 8'h01 : 8'h00;
    sum      = {1'b0, acc_reg} + {{(ACC_W+1-INC_W){1'b0}}, inc};
    if (!enabled) begin
      cnt_next = 8'h00;
    end else if (incValid) begin
      if (limit != {ACC_W{1'b0}} && sum >= {1'b0, limit}) begin
        acc_next = sum[ACC_W-1:0] - limit;
        cnt_next = LEN;
      end else begin
        acc_next = sum[ACC_W-1:0];
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      acc_reg <= {ACC_W{1'b0}};
      cnt_reg <= 8'h00;
      out_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      cnt_reg <= cnt_next;
      out_reg <= (cnt_next != 8'h00);
    end
  end

  assign pulseOut = out_reg;

endmodule

// File: core/olp_top.v
// Purpose: Over-limit detection per phase and pulse pin routing registers
// Assumes: Samples and energy strobes come from logic on clk; register port
//          is the device's internal word-addressed access path
// Notes:   Read data appears one cycle after the read strobe
`timescale 1ns/100ps
`include "olp_defs.vh"

module olp_top #(
  parameter SAMPLE_W  = 24,
  parameter INC_W     = 16,
  parameter ACC_W     = 32,
  parameter PULSE_LEN = 4
) (
  // Clock and reset
  input  wire                                  clk,
  input  wire                                  rst,
  // Register port
  input  wire [`OLP_ADDR_W-1:0]                regAddr,
  input  wire                                  regWrEn,
  input  wire [`OLP_DATA_W-1:0]                regWrData,
  input  wire                                  regRdEn,
  output wire [`OLP_DATA_W-1:0]                regRdData,
  output wire                                  regRdValid,
  // Phase samples, A in the lowest slice
  input  wire [`OLP_NUM_PHASE*SAMPLE_W-1:0]    voltSample,
  input  wire [`OLP_NUM_PHASE-1:0]             voltValid,
  input  wire [`OLP_NUM_PHASE*SAMPLE_W-1:0]    currSample,
  input  wire [`OLP_NUM_PHASE-1:0]             currValid,
  // Event control and status
  input  wire                                  overLimitIrqEnable,
  input  wire                                  ovEventClear,
  input  wire                                  ocEventClear,
  output wire [`OLP_NUM_PHASE-1:0]             phaseOvFlag,
  output wire [`OLP_NUM_PHASE-1:0]             phaseOcFlag,
  output wire                                  ovEventFlag,
  output wire                                  ocEventFlag,
  output wire                                  irqReq,
  // Energy sources and pulse constants
  input  wire [`OLP_NUM_SRC*INC_W-1:0]         energyInc,
  input  wire [`OLP_NUM_SRC-1:0]               energyValid,
  input  wire [ACC_W-1:0]                      pulseConstA,
  input  wire [ACC_W-1:0]                      pulseConstB,
  // Pulse pins
  output wire [`OLP_NUM_OUT-1:0]               pulseOut
);

  // ==========================================================================
  // Magnitude helper
  // The most negative sample wraps to itself, which is still the right
  // unsigned magnitude, so no saturation is needed.
  function [`OLP_CMP_W-1:0] absHigh;
    input [SAMPLE_W-1:0] s;
    reg   [SAMPLE_W-1:0] a;
    begin
      a = s[SAMPLE_W-1] ? (~s + 1'b1) : s;
      absHigh = a[SAMPLE_W-1 -: `OLP_CMP_W];
    end
  endfunction

  // ==========================================================================
  // Registers
  reg  [`OLP_THR_W-1:0]       ovThr_reg;
  reg  [`OLP_THR_W-1:0]       ocThr_reg;
  reg  [`OLP_DATA_W-1:0]      pulseCfg_reg;
  reg  [`OLP_DATA_W-1:0]      rdData_reg;
  reg  [`OLP_DATA_W-1:0]      rdData_next;
  reg                         rdValid_reg;

  always @(posedge clk) begin
    if (rst) begin
      ovThr_reg    <= `OLP_THR_RST;
      ocThr_reg    <= `OLP_THR_RST;
      pulseCfg_reg <= `OLP_PPCFG_RST;
    end else if (regWrEn) begin
      case (regAddr)
        `OLP_ADDR_OVTHR: begin
          ovThr_reg <= regWrData[`OLP_THR_W-1:0];
        end
        `OLP_ADDR_OCTHR: begin
          ocThr_reg <= regWrData[`OLP_THR_W-1:0];
        end
        `OLP_ADDR_PPCFG: begin
          pulseCfg_reg <= regWrData & `OLP_PPCFG_MASK;
        end
        default: begin
          ovThr_reg <= ovThr_reg;
        end
      endcase
    end
  end

  // Unmapped addresses read as zero; a read in the same cycle as a write
  // returns the value held before the write.
  always @* begin
    case (regAddr)
      `OLP_ADDR_OVTHR: rdData_next = {8'h00, ovThr_reg};
      `OLP_ADDR_OCTHR: rdData_next = {8'h00, ocThr_reg};
      `OLP_ADDR_PPCFG: rdData_next = pulseCfg_reg;
      default:         rdData_next = {`OLP_DATA_W{1'b0}};
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      rdData_reg  <= {`OLP_DATA_W{1'b0}};
      rdValid_reg <= 1'b0;
    end else begin
      rdValid_reg <= regRdEn;
      if (regRdEn) begin
        rdData_reg <= rdData_next;
      end
    end
  end

  assign regRdData  = rdData_reg;
  assign regRdValid = rdValid_reg;

  // ==========================================================================
  // Over-limit comparison, one comparator pair per phase
  wire [`OLP_NUM_PHASE-1:0] ovHit;
  wire [`OLP_NUM_PHASE-1:0] ocHit;
  wire                      ovArmed;
  wire                      ocArmed;

  assign ovArmed = (ovThr_reg != `OLP_THR_RST);
  assign ocArmed = (ocThr_reg != `OLP_THR_RST);

  genvar p;
  generate
    for (p = 0; p < `OLP_NUM_PHASE; p = p + 1) begin : gPhase
      // Each phase is judged on its own sample strobe only
      assign ovHit[p] = ovArmed && voltValid[p] &&
                        (absHigh(voltSample[p*SAMPLE_W +: SAMPLE_W]) > ovThr_reg);
      assign ocHit[p] = ocArmed && currValid[p] &&
                        (absHigh(currSample[p*SAMPLE_W +: SAMPLE_W]) > ocThr_reg);
    end
  endgenerate

  // ==========================================================================
  // Sticky flags; a new hit in the clearing cycle wins over the clear
  reg  [`OLP_NUM_PHASE-1:0] phaseOv_reg;
  reg  [`OLP_NUM_PHASE-1:0] phaseOv_next;
  reg  [`OLP_NUM_PHASE-1:0] phaseOc_reg;
  reg  [`OLP_NUM_PHASE-1:0] phaseOc_next;
  reg                       ovEvent_reg;
  reg                       ovEvent_next;
  reg                       ocEvent_reg;
  reg                       ocEvent_next;
  reg                       irq_reg;
  reg                       irq_next;

  always @* begin
    phaseOv_next = ovHit | (phaseOv_reg & {`OLP_NUM_PHASE{~ovEventClear}});
    ovEvent_next = (|ovHit) | (ovEvent_reg & ~ovEventClear);
    phaseOc_next = ocHit | (phaseOc_reg & {`OLP_NUM_PHASE{~ocEventClear}});
    ocEvent_next = (|ocHit) | (ocEvent_reg & ~ocEventClear);
    // Request follows the flags, so clearing both withdraws it
    irq_next     = overLimitIrqEnable & (ovEvent_next | ocEvent_next);
  end

  always @(posedge clk) begin
    if (rst) begin
      phaseOv_reg <= {`OLP_NUM_PHASE{1'b0}};
      phaseOc_reg <= {`OLP_NUM_PHASE{1'b0}};
      ovEvent_reg <= 1'b0;
      ocEvent_reg <= 1'b0;
      irq_reg     <= 1'b0;
    end else begin
      phaseOv_reg <= phaseOv_next;
      phaseOc_reg <= phaseOc_next;
      ovEvent_reg <= ovEvent_next;
      ocEvent_reg <= ocEvent_next;
      irq_reg     <= irq_next;
    end
  end

  assign phaseOvFlag = phaseOv_reg;
  assign phaseOcFlag = phaseOc_reg;
  assign ovEventFlag = ovEvent_reg;
  assign ocEventFlag = ocEvent_reg;
  assign irqReq      = irq_reg;

  // ==========================================================================
  // Pulse pin routing
  // Fields repeat every four bits: selector in the low three, constant pick
  // on top. Output 1 alone treats the reserved code as total active.
  genvar k;
  generate
    for (k = 0; k < `OLP_NUM_OUT; k = k + 1) begin : gPulse
      olp_pulse_gen #(
        .ACC_W     (ACC_W),
        .INC_W     (INC_W),
        .PULSE_LEN (PULSE_LEN),
        .ALIAS_RSV ((k == 0) ? 1 : 0)
      ) uPulse (
        .clk         (clk),
        .rst         (rst),
        .srcSel      (pulseCfg_reg[`OLP_SEL1_LSB + k*`OLP_FIELD_STRIDE +:
                      `OLP_SEL_W]),
        .constSel    (pulseCfg_reg[`OLP_CSEL1_BIT + k*`OLP_FIELD_STRIDE]),
        .constA      (pulseConstA),
        .constB      (pulseConstB),
        .energyInc   (energyInc),
        .energyValid (energyValid),
        .pulseOut    (pulseOut[k])
      );
    end
  endgenerate

endmodule

// File: sim/olp_top_chk.sv
// Purpose: Port-level checks for the over-limit and pulse routing block
// Assumes: Single clock, synchronous active-high reset
// Notes:   Thresholds are internal, so checks tie flags to strobes and clears
`timescale 1ns/100ps
`include "olp_defs.vh"

module olp_top_chk (
  // Clock and reset
  input wire                        clk,
  input wire                        rst,
  // Register port
  input wire                        regRdEn,
  input wire                        regRdValid,
  // Samples and event control
  input wire [`OLP_NUM_PHASE-1:0]   voltValid,
  input wire [`OLP_NUM_PHASE-1:0]   currValid,
  input wire                        overLimitIrqEnable,
  input wire                        ovEventClear,
  input wire                        ocEventClear,
  input wire [`OLP_NUM_PHASE-1:0]   phaseOvFlag,
  input wire [`OLP_NUM_PHASE-1:0]   phaseOcFlag,
  input wire                        ovEventFlag,
  input wire                        ocEventFlag,
  input wire                        irqReq,
  // Pulses
  input wire [`OLP_NUM_SRC-1:0]     energyValid,
  input wire [`OLP_NUM_OUT-1:0]     pulseOut
);
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_RD_ACK: assert property (regRdEn |=> regRdValid)
    else $error("read strobe got no answer");
  AST_RD_QUIET: assert property (!regRdEn |=> !regRdValid)
    else $error("read answer without a strobe");
  AST_OV_SUM: assert property (phaseOvFlag != 3'h0 |-> ovEventFlag)
    else $error("phase overvoltage flag without event flag");
  AST_OC_SUM: assert property (phaseOcFlag != 3'h0 |-> ocEventFlag)
    else $error("phase overcurrent flag without event flag");
  AST_OV_CLR: assert property (ovEventClear && voltValid == 3'h0 |=>
      !ovEventFlag && phaseOvFlag == 3'h0)
    else $error("overvoltage clear left a flag");
  AST_OC_CLR: assert property (ocEventClear && currValid == 3'h0 |=>
      !ocEventFlag && phaseOcFlag == 3'h0)
    else $error("overcurrent clear left a flag");
  AST_OV_HOLD: assert property (ovEventFlag && !ovEventClear |=> ovEventFlag)
    else $error("overvoltage event dropped without clear");
  AST_PH_SRC: assert property ($rose(phaseOcFlag[1]) |-> $past(currValid[1]))
    else $error("phase B overcurrent set without a sample");
  AST_IRQ_ON: assert property (($rose(ovEventFlag) || $rose(ocEventFlag))
      && $past(overLimitIrqEnable) |-> irqReq)
    else $error("enabled event raised no interrupt");
  AST_IRQ_OFF: assert property (!ovEventFlag && !ocEventFlag |-> !irqReq)
    else $error("interrupt without an event");
  AST_PULSE_SRC: assert property ((pulseOut & ~$past(pulseOut)) != 4'h0
      |-> $past(energyValid) != 6'h00)
    else $error("pulse rose without an energy strobe");

  CV_OV_IRQ: cover property ($rose(ovEventFlag) && irqReq);
  CV_OC: cover property ($rose(ocEventFlag));
  CV_PULSE4: cover property ($rose(pulseOut[3]));
endmodule

bind olp_top olp_top_chk chk_i (.*);

// File: sim/tb_top.sv
// Purpose: Self-checking bench for the over-limit and pulse routing block
// Assumes: Inputs driven on the falling edge, outputs sampled there too
// Notes:   Energy increments equal constant a and half constant b, so no remainder carries over
`timescale 1ns/100ps
`include "olp_defs.vh"

module tb_top;
  // ==========================================================================
  // Signals
  localparam int PL = 4;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [6:0]  regAddr = 7'h00;
  logic        regWrEn = 1'b0;
  logic [23:0] regWrData = 24'h000000;
  logic        regRdEn = 1'b0;
  logic [23:0] regRdData;
  logic        regRdValid;
  logic [71:0] voltSample = '0;
  logic [2:0]  voltValid = 3'h0;
  logic [71:0] currSample = '0;
  logic [2:0]  currValid = 3'h0;
  logic        overLimitIrqEnable = 1'b0;
  logic        ovEventClear = 1'b0;
  logic        ocEventClear = 1'b0;
  logic [2:0]  phaseOvFlag;
  logic [2:0]  phaseOcFlag;
  logic        ovEventFlag;
  logic        ocEventFlag;
  logic        irqReq;
  logic [95:0] energyInc = '0;
  logic [5:0]  energyValid = 6'h00;
  logic [31:0] pulseConstA = 32'h0000000A;
  logic [31:0] pulseConstB = 32'h00000014;
  logic [3:0]  pulseOut;
  int          error_cnt = 0;
  int          compares = 0;

  olp_top #(.PULSE_LEN(PL)) dut (.*);

  initial begin
    forever #10 clk = ~clk;
  end

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [23:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
  endtask

  task automatic rchk(input logic [6:0] a, input logic [23:0] exp, input string msg);
    @(negedge clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk);
    regRdEn = 1'b0;
    chk(regRdValid, 1'b1, "read answer");
    chk(regRdData, exp, msg);
  endtask

  task automatic hit(input bit cur, input logic [2:0] ph, input logic [23:0] s);
    @(negedge clk);
    voltSample = {3{s}};
    currSample = {3{s}};
    voltValid = cur ? 3'h0 : ph;
    currValid = cur ? ph : 3'h0;
    @(negedge clk);
    voltValid = 3'h0;
    currValid = 3'h0;
  endtask

  task automatic clr(input bit cur);
    @(negedge clk);
    ovEventClear = ~cur;
    ocEventClear = cur;
    @(negedge clk);
    ovEventClear = 1'b0;
    ocEventClear = 1'b0;
  endtask

  task automatic strobe(input logic [5:0] v);
    @(negedge clk);
    energyValid = v;
    @(negedge clk);
    energyValid = 6'h00;
  endtask

  function automatic logic [4:0] fl(input bit cur);
    return cur ? {irqReq, ocEventFlag, phaseOcFlag} : {irqReq, ovEventFlag, phaseOvFlag};
  endfunction

  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    rchk(`OLP_ADDR_OVTHR, 24'h000000, "ov limit reset");
    rchk(`OLP_ADDR_OCTHR, 24'h000000, "oc limit reset");
    rchk(`OLP_ADDR_PPCFG, 24'h043210, "config reset");
    wr(`OLP_ADDR_OVTHR, 24'hFFA5C3);
    wr(`OLP_ADDR_OCTHR, 24'hFF3C5A);
    wr(`OLP_ADDR_PPCFG, 24'hFFFFFF);
    wr(7'h5B, 24'h123456);
    rchk(`OLP_ADDR_OVTHR, 24'h00A5C3, "ov limit");
    rchk(`OLP_ADDR_OCTHR, 24'h003C5A, "oc limit");
    rchk(`OLP_ADDR_PPCFG, 24'h07FFFF, "config");
    rchk(7'h5B, 24'h000000, "unmapped");
    $display("test registers done");
  endtask

  task automatic t_limit(input bit cur);
    logic [6:0] a;
    a = cur ? `OLP_ADDR_OCTHR : `OLP_ADDR_OVTHR;
    overLimitIrqEnable = 1'b0;
    wr(a, 24'h000000);
    hit(cur, 3'h7, 24'h7FFF00);
    chk(fl(cur), 5'h00, "zero limit");
    wr(a, 24'h001000);
    hit(cur, 3'h7, 24'h1000FF);
    chk(fl(cur), 5'h00, "equal value");
    hit(cur, 3'h4, 24'h100100);
    chk(fl(cur), 5'b01100, "phase C over");
    repeat (3) @(negedge clk);
    chk(fl(cur), 5'b01100, "flag held");
    clr(cur);
    chk(fl(cur), 5'h00, "cleared");
    overLimitIrqEnable = 1'b1;
    hit(cur, 3'h2, 24'hEFFF00);
    chk(fl(cur), 5'b11010, "negative B with irq");
    fork
      clr(cur);
      hit(cur, 3'h1, 24'h7FFF00);
    join
    chk(fl(cur), 5'b11001, "hit beats clear");
    clr(cur);
    chk(fl(cur), 5'h00, "irq cleared");
    overLimitIrqEnable = 1'b0;
    $display("test limit %0d done", cur);
  endtask

  task automatic t_pulse();
    logic [3:0] exp;
    energyInc = {6{16'h000A}};
    for (int c = 0; c < 8; c++) begin
      wr(`OLP_ADDR_PPCFG, {8'h00, {4{1'b0, c[2:0]}}});
      for (int s = 0; s < 6; s++) begin
        exp = {4{c == s}};
        exp[0] = (c == s) || (c == 6 && s == 0);
        strobe(6'h01 << s);
        chk(pulseOut, exp, "route");
        repeat (PL) @(negedge clk);
        chk(pulseOut, 4'h0, "pulse end");
      end
    end
    wr(`OLP_ADDR_PPCFG, 24'h008888);
    strobe(6'h01);
    chk(pulseOut, 4'h0, "constant b half");
    strobe(6'h01);
    chk(pulseOut, 4'hF, "constant b reached");
    $display("test pulse done");
  endtask

  // ==========================================================================
  // Run control
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    error_cnt++;
    $display("unexpected at %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_regs();
    t_limit(1'b0);
    t_limit(1'b1);
    t_pulse();
    finish_test();
  end
endmodule
